// [design/ila_level_regs.sv]
// module: interrupt level assignment registers with request gating
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
// Contract
// - level 000 disables source, request blocked
// - levels 001..111 enable, value is level
// - all fields reset to 000
// - fields read back last written value
// - bank0 bits 26:24 level of source 23
// - bank0 bits 18:16 level of source 22
// - bank0 bits 10:8 level of source 7
// - bank0 bits 2:0 level of source 6
// - bank1 bits 26:24 level of source 25
// - bank1 bits 18:16 level of source 24
// - bank1 bits 10:8 level of source 9
// - bank1 bits 2:0 level of source 8
// - reserved bits read zero, no function
module ila_level_regs
   import ila_pkg::*;
(
   // clock and reset
   input  wire logic                 CLK_SYS,
   input  wire logic                 ARST_N,
   // register port
   input  wire logic [15:0]          ADDR,
   input  wire logic [31:0]          WDATA,
   input  wire logic                 WR,
   input  wire logic                 RD,
   output logic      [31:0]          RDATA,
   // sources and arbitration side
   input  wire logic [ILA_NSRC-1:0]  SRC_REQ,
   output ila_levels_t               LEVELS,
   output logic      [ILA_NSRC-1:0]  REQ_FWD,
   // interrupt
   output logic                      IRQ
);
   // ==========================================================
   // storage
   ila_bus_t          bus;
   logic [31:0]       bank0_r;
   logic [31:0]       bank1_r;
   logic [1:0]        evt_sts_r;
   logic [1:0]        evt_en_r;
   logic [1:0]        evt_nxt;
   logic [1:0]        evt_en_nxt;
   logic [31:0]       rdata_nxt;
   logic [ILA_NSRC-1:0] fwd_nxt;
   ila_lvl_t          lvl_vec [ILA_NSRC];

   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   function automatic logic is_bank(input logic [15:0] a);
      is_bank = (a == ILA_OFF_BANK_PCI_EXT) ||
                (a == ILA_OFF_BANK_AUDIO_SERIAL);
   endfunction

   function automatic logic is_mapped(input logic [15:0] a);
      is_mapped = is_bank(a) || (a == ILA_OFF_IRQ_STATUS) ||
                  (a == ILA_OFF_IRQ_ENABLE) || (a == ILA_OFF_IRQ_CLEAR);
   endfunction

   // ==========================================================
   // level banks
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         bank0_r <= ILA_DATA_RESET;
      end else if (bus.wr && bus.addr == ILA_OFF_BANK_PCI_EXT) begin
         bank0_r <= bus.wdata & ILA_FIELD_MASK;
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         bank1_r <= ILA_DATA_RESET;
      end else if (bus.wr && bus.addr == ILA_OFF_BANK_AUDIO_SERIAL) begin
         bank1_r <= bus.wdata & ILA_FIELD_MASK;
      end
   end

   // ==========================================================
   // field mapping
   assign lvl_vec[0] = bank0_r[ILA_POS_F0 +: ILA_LVL_W];
   assign lvl_vec[1] = bank0_r[ILA_POS_F1 +: ILA_LVL_W];
   assign lvl_vec[2] = bank0_r[ILA_POS_F2 +: ILA_LVL_W];
   assign lvl_vec[3] = bank0_r[ILA_POS_F3 +: ILA_LVL_W];
   assign lvl_vec[4] = bank1_r[ILA_POS_F0 +: ILA_LVL_W];
   assign lvl_vec[5] = bank1_r[ILA_POS_F1 +: ILA_LVL_W];
   assign lvl_vec[6] = bank1_r[ILA_POS_F2 +: ILA_LVL_W];
   assign lvl_vec[7] = bank1_r[ILA_POS_F3 +: ILA_LVL_W];

   // levels to arbitration, registered once
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         LEVELS <= '0;
      end else begin
         LEVELS <= {lvl_vec[7], lvl_vec[6], lvl_vec[5], lvl_vec[4],
                    lvl_vec[3], lvl_vec[2], lvl_vec[1], lvl_vec[0]};
      end
   end

   // ==========================================================
   // request gating
   generate
      for (genvar i = 0; i < ILA_NSRC; i++) begin : g_fwd
         assign fwd_nxt[i] = SRC_REQ[i] && (lvl_vec[i] != ILA_LVL_OFF);
      end
   endgenerate

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         REQ_FWD <= '0;
      end else begin
         REQ_FWD <= fwd_nxt;
      end
   end

   // ==========================================================
   // event status, enable, clear
   always_comb begin
      evt_nxt = evt_sts_r;
      if (bus.wr && bus.addr == ILA_OFF_IRQ_CLEAR) begin
         evt_nxt = evt_nxt & ~bus.wdata[1:0];
      end
      if (bus.wr && is_bank(bus.addr)) begin
         evt_nxt[ILA_EVT_LVL_WR] = 1'b1;
      end
      if (bus.wr && !is_mapped(bus.addr)) begin
         evt_nxt[ILA_EVT_BAD_WR] = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         evt_sts_r <= ILA_EVT_RESET;
      end else begin
         evt_sts_r <= evt_nxt;
      end
   end

   always_comb begin
      evt_en_nxt = evt_en_r;
      if (bus.wr && bus.addr == ILA_OFF_IRQ_ENABLE) begin
         evt_en_nxt = bus.wdata[1:0];
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         evt_en_r <= ILA_EVT_RESET;
      end else begin
         evt_en_r <= evt_en_nxt;
      end
   end

   // built from next status and next enable, so it lags neither
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(evt_nxt & evt_en_nxt);
      end
   end

   // ==========================================================
   // read path
   always_comb begin
      rdata_nxt = ILA_DATA_RESET;
      if (bus.addr == ILA_OFF_BANK_PCI_EXT) begin
         rdata_nxt = bank0_r;
      end else if (bus.addr == ILA_OFF_BANK_AUDIO_SERIAL) begin
         rdata_nxt = bank1_r;
      end else if (bus.addr == ILA_OFF_IRQ_STATUS) begin
         rdata_nxt = {30'h0, evt_sts_r};
      end else if (bus.addr == ILA_OFF_IRQ_ENABLE) begin
         rdata_nxt = {30'h0, evt_en_r};
      end
   end

   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         RDATA <= ILA_DATA_RESET;
      end else if (bus.rd) begin
         RDATA <= rdata_nxt;
      end else begin
         RDATA <= ILA_DATA_RESET;
      end
   end

   // ==========================================================
   // checks
   sequence s_bank0_write;
      bus.wr && bus.addr == ILA_OFF_BANK_PCI_EXT;
   endsequence

   sequence s_bank0_read;
      bus.rd && bus.addr == ILA_OFF_BANK_PCI_EXT;
   endsequence

   a_disabled_blocks: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (LEVELS.level_src6 == ILA_LVL_OFF) |-> !REQ_FWD[0])
      else $error("request forwarded for disabled source 6");

   a_enabled_forwards: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (SRC_REQ[2] && lvl_vec[2] != ILA_LVL_OFF) |=> REQ_FWD[2])
      else $error("enabled source 22 not forwarded");

   a_reset_levels: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      $rose(ARST_N) |-> (bank0_r == 32'h0 && bank1_r == 32'h0))
      else $error("level banks not zero after reset");

   a_bank_readback: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      s_bank0_write ##1 s_bank0_read |=>
      RDATA == ($past(bus.wdata, 2) & 32'h07070707))
      else $error("bank read does not return written value");

   a_src23_field: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      s_bank0_write |=> ##1 LEVELS.level_src23 == $past(bus.wdata[26:24], 2))
      else $error("source 23 level wrong");

   a_src22_field: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      s_bank0_write |=> ##1 LEVELS.level_src22 == $past(bus.wdata[18:16], 2))
      else $error("source 22 level wrong");

   a_src7_field: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      s_bank0_write |=> ##1 LEVELS.level_src7 == $past(bus.wdata[10:8], 2))
      else $error("source 7 level wrong");

   a_src6_field: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      s_bank0_write |=> ##1 LEVELS.level_src6 == $past(bus.wdata[2:0], 2))
      else $error("source 6 level wrong");

   a_src25_24_fields: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (bus.wr && bus.addr == ILA_OFF_BANK_AUDIO_SERIAL) |=> ##1
      {LEVELS.level_src25, LEVELS.level_src24} ==
      {$past(bus.wdata[26:24], 2), $past(bus.wdata[18:16], 2)})
      else $error("source 25 or 24 level wrong");

   a_src9_8_fields: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (bus.wr && bus.addr == ILA_OFF_BANK_AUDIO_SERIAL) |=> ##1
      {LEVELS.level_src9, LEVELS.level_src8} ==
      {$past(bus.wdata[10:8], 2), $past(bus.wdata[2:0], 2)})
      else $error("source 9 or 8 level wrong");

   a_reserved_zero: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      s_bank0_read |=> (RDATA & ~ILA_FIELD_MASK) == 32'h0)
      else $error("reserved bits read nonzero");

   a_level_stable: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      !bus.wr [*3] |-> $stable(LEVELS))
      else $error("levels changed without a write");

   sequence s_bank1_write;
      bus.wr && bus.addr == ILA_OFF_BANK_AUDIO_SERIAL;
   endsequence

   sequence s_bank1_read;
      bus.rd && bus.addr == ILA_OFF_BANK_AUDIO_SERIAL;
   endsequence

   sequence s_clear_write;
      bus.wr && bus.addr == ILA_OFF_IRQ_CLEAR;
   endsequence

   a_bank1_readback: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      s_bank1_write ##1 s_bank1_read |=>
      RDATA == ($past(bus.wdata, 2) & 32'h07070707))
      else $error("bank 1 read does not return written value");

   a_rdata_idle: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      !bus.rd |=> RDATA == 32'h0)
      else $error("read data present without a read");

   a_reserved_bank1: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      s_bank1_read |=> (RDATA & ~ILA_FIELD_MASK) == 32'h0)
      else $error("bank 1 reserved bits read nonzero");

   a_reserved_stored: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      ((bank0_r | bank1_r) & ~ILA_FIELD_MASK) == 32'h0)
      else $error("reserved bits stored in a level bank");

   a_other_write_kept: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (bus.wr && !is_bank(bus.addr)) |=>
      $stable(bank0_r) && $stable(bank1_r))
      else $error("level bank changed by another write");

   a_reset_outputs: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      $rose(ARST_N) |-> (LEVELS == '0 && REQ_FWD == '0 && !IRQ))
      else $error("outputs not cleared after reset");

   generate
      for (genvar k = 0; k < ILA_NSRC; k++) begin : g_chk
         a_gate_each: assert property (
            @(posedge CLK_SYS) disable iff (!ARST_N)
            REQ_FWD[k] == $past(SRC_REQ[k] && lvl_vec[k] != ILA_LVL_OFF))
            else $error("request gating wrong for a source");
      end
   endgenerate

   a_irq_level: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      IRQ == |(evt_sts_r & evt_en_r))
      else $error("interrupt disagrees with status and enable");

   a_status_sticky: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      !(bus.wr && bus.addr == ILA_OFF_IRQ_CLEAR) |=>
      (evt_sts_r & $past(evt_sts_r)) == $past(evt_sts_r))
      else $error("status bit fell without a clear");

   a_clear_status: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      s_clear_write |=> (evt_sts_r & $past(bus.wdata[1:0])) == 2'h0)
      else $error("status bit not cleared");

   a_level_write_flag: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (bus.wr && is_bank(bus.addr)) |=> evt_sts_r[ILA_EVT_LVL_WR])
      else $error("level bank write did not set status");

   a_bad_write_flag: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (bus.wr && !is_mapped(bus.addr)) |=> evt_sts_r[ILA_EVT_BAD_WR])
      else $error("unmapped write did not set status");

   a_enable_write: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (bus.wr && bus.addr == ILA_OFF_IRQ_ENABLE) |=>
      evt_en_r == $past(bus.wdata[1:0]))
      else $error("enable register not written");

   a_clear_read_zero: assert property (
      @(posedge CLK_SYS) disable iff (!ARST_N)
      (bus.rd && bus.addr == ILA_OFF_IRQ_CLEAR) |=> RDATA == 32'h0)
      else $error("clear register read nonzero");

endmodule // ila_level_regs

// [design/ila_pkg.sv]
// package: offsets, field layout, resets and types of the level registers
package ila_pkg;
   // ==========================================================
   // register map
   localparam logic [15:0] ILA_OFF_BANK_PCI_EXT      = 16'hf61c;
   localparam logic [15:0] ILA_OFF_BANK_AUDIO_SERIAL = 16'hf620;
   localparam logic [15:0] ILA_OFF_IRQ_STATUS        = 16'hf680;
   localparam logic [15:0] ILA_OFF_IRQ_ENABLE        = 16'hf684;
   localparam logic [15:0] ILA_OFF_IRQ_CLEAR         = 16'hf688;
   // ==========================================================
   // field layout
   localparam int ILA_NSRC      = 8;
   localparam int ILA_LVL_W     = 3;
   localparam int ILA_POS_F0    = 0;
   localparam int ILA_POS_F1    = 8;
   localparam int ILA_POS_F2    = 16;
   localparam int ILA_POS_F3    = 24;
   localparam logic [31:0] ILA_FIELD_MASK = 32'h07070707;
   localparam logic [2:0]  ILA_LVL_RESET  = 3'h0;
   localparam logic [2:0]  ILA_LVL_OFF    = 3'h0;
   localparam logic [31:0] ILA_DATA_RESET = 32'h00000000;
   localparam logic [1:0]  ILA_EVT_RESET  = 2'h0;
   // event bits: write to a level bank, write to an unmapped address
   localparam int ILA_EVT_LVL_WR = 0;
   localparam int ILA_EVT_BAD_WR = 1;
   // ==========================================================
   // types
   typedef logic [2:0] ila_lvl_t;
   // source order: 6,7,22,23,8,9,24,25
   typedef struct packed {
      ila_lvl_t level_src25;
      ila_lvl_t level_src24;
      ila_lvl_t level_src9;
      ila_lvl_t level_src8;
      ila_lvl_t level_src23;
      ila_lvl_t level_src22;
      ila_lvl_t level_src7;
      ila_lvl_t level_src6;
   } ila_levels_t;
   typedef struct packed {
      logic [15:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ila_bus_t;
endpackage : ila_pkg

// [tb/ila_src_model.sv]
// far-side model: interrupt sources raising level requests
`timescale 1ns/1ns
module ila_src_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // wanted requests, raised one edge later as level requests
   input  wire logic [7:0] raise,
   output logic      [7:0] src_req
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         src_req <= 8'h00;
      end else begin
         src_req <= raise;
      end
   end
endmodule // ila_src_model

// [tb/interrupt_level_assign_regs_bench.sv]
// testbench: level banks, request gating and interrupt registers
`timescale 1ns/1ns
module interrupt_level_assign_regs_bench;
   import ila_pkg::*;
   // ==========================================================
   // signals
   logic        CLK_SYS, ARST_N, WR, RD, IRQ;
   logic [15:0] ADDR;
   logic [31:0] WDATA, RDATA, v;
   logic [7:0]  raise, SRC_REQ, REQ_FWD;
   ila_levels_t LEVELS;
   int          miscompares, total_checks;
   localparam logic [15:0] BK0 = ILA_OFF_BANK_PCI_EXT;
   localparam logic [15:0] BK1 = ILA_OFF_BANK_AUDIO_SERIAL;
   localparam logic [15:0] BAD = 16'hf700;
   // ==========================================================
   // instances
   ila_level_regs u_ila_level_regs (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .SRC_REQ(SRC_REQ), .LEVELS(LEVELS), .REQ_FWD(REQ_FWD), .IRQ(IRQ));
   ila_src_model u_ila_src_model (.clk(CLK_SYS), .rst_n(ARST_N),
      .raise(raise), .src_req(SRC_REQ));
   // ==========================================================
   // tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK_SYS);
      WR    <= 1'b0;
   endtask
   task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
      @(posedge CLK_SYS);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLK_SYS);
      RD   <= 1'b0;
      #1 d = RDATA;
   endtask
   task automatic wr_rd_reg(input logic [15:0] a, input logic [31:0] d,
                            output logic [31:0] q);
      @(posedge CLK_SYS);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK_SYS);
      WR    <= 1'b0;
      RD    <= 1'b1;
      @(posedge CLK_SYS);
      RD    <= 1'b0;
      #1 q = RDATA;
   endtask
   task automatic settle;
      repeat (2) @(posedge CLK_SYS);
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ==========================================================
   // clock, reset, watchdog
   initial begin
      CLK_SYS = 1'b0;
      forever #50 CLK_SYS = ~CLK_SYS;
   end
   initial begin
      repeat (5000) @(posedge CLK_SYS);
      miscompares++;
      complete_run();
   end
   // ==========================================================
   // main sequence
   initial begin
      ARST_N = 1'b0; WR = 1'b0; RD = 1'b0; ADDR = 16'h0000;
      WDATA = 32'h0; raise = 8'hff; miscompares = 0; total_checks = 0;
      repeat (4) @(posedge CLK_SYS);
      ARST_N <= 1'b1;
      settle();
      check(32'(LEVELS), 32'h0);
      check(32'(REQ_FWD), 32'h0);
      rd_reg(BK0, v); check(v, 32'h0);
      rd_reg(BK1, v); check(v, 32'h0);
      wr_reg(BK0, 32'hffffffff);
      rd_reg(BK0, v); check(v, ILA_FIELD_MASK);
      @(posedge CLK_SYS); #1 check(RDATA, 32'h0);
      wr_reg(BK0, 32'hf9f2fbf4);
      rd_reg(BK0, v); check(v, 32'h01020304);
      check(32'(LEVELS.level_src23), 32'h1);
      check(32'(LEVELS.level_src22), 32'h2);
      check(32'(LEVELS.level_src7), 32'h3);
      check(32'(LEVELS.level_src6), 32'h4);
      check(32'(REQ_FWD), 32'h0f);
      wr_reg(BK1, 32'h05060700);
      settle();
      check(32'(LEVELS.level_src25), 32'h5);
      check(32'(LEVELS.level_src24), 32'h6);
      check(32'(LEVELS.level_src9), 32'h7);
      check(32'(LEVELS.level_src8), 32'h0);
      check(32'(REQ_FWD), 32'hef);
      for (int i = 0; i < 8; i++) begin
         wr_reg(BK0, 32'(i));
         settle();
         check(32'(LEVELS.level_src6), 32'(i));
         check(32'(REQ_FWD[3:0]), (i != 0) ? 32'h1 : 32'h0);
      end
      raise <= 8'h00;
      settle();
      check(32'(REQ_FWD), 32'h0);
      wr_rd_reg(BK0, 32'h12345678, v); check(v, 32'h02040600);
      wr_rd_reg(BK1, 32'hfedcba98, v); check(v, 32'h06040200);
      check(32'(LEVELS.level_src24), 32'h4);
      // interrupt: raise, mask, clear
      wr_reg(ILA_OFF_IRQ_CLEAR, 32'h3);
      wr_reg(ILA_OFF_IRQ_ENABLE, 32'h1);
      rd_reg(ILA_OFF_IRQ_ENABLE, v); check(v, 32'h1);
      check(32'(IRQ), 32'h0);
      wr_reg(BK1, 32'h0);
      settle(); check(32'(IRQ), 32'h1);
      wr_reg(ILA_OFF_IRQ_ENABLE, 32'h0);
      settle(); check(32'(IRQ), 32'h0);
      wr_reg(BAD, 32'hffffffff);
      rd_reg(ILA_OFF_IRQ_STATUS, v); check(v, 32'h3);
      rd_reg(BAD, v); check(v, 32'h0);
      rd_reg(BK1, v); check(v, 32'h0);
      wr_reg(ILA_OFF_IRQ_ENABLE, 32'h2);
      settle(); check(32'(IRQ), 32'h1);
      wr_reg(ILA_OFF_IRQ_CLEAR, 32'h3);
      settle(); check(32'(IRQ), 32'h0);
      rd_reg(ILA_OFF_IRQ_STATUS, v); check(v, 32'h0);
      rd_reg(ILA_OFF_IRQ_CLEAR, v); check(v, 32'h0);
      wr_reg(BK1, 32'h07070707);
      raise  <= 8'hff;
      ARST_N <= 1'b0;
      repeat (4) @(posedge CLK_SYS);
      ARST_N <= 1'b1;
      settle();
      check(32'(LEVELS), 32'h0);
      check(32'(REQ_FWD), 32'h0);
      check(32'(IRQ), 32'h0);
      rd_reg(BK1, v); check(v, 32'h0);
      rd_reg(ILA_OFF_IRQ_STATUS, v); check(v, 32'h0);
      complete_run();
   end
endmodule // interrupt_level_assign_regs_bench
